// ---- rtl/qaso_fifo.sv ----
`timescale 1ns/100ps

module qaso_fifo
  import qaso_pkg::*;
#(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // Word storage
    logic [AW-1:0]               wr;    // Write index
    logic [AW-1:0]               rd;    // Read index
    logic [AW:0]                 cnt;   // Words held
  } qaso_fifo_st_t;

  qaso_fifo_st_t st_reg;                // Registered state
  qaso_fifo_st_t st_next;               // Next state
  logic          push;                  // Word accepted
  logic          pop;                   // Word delivered

  assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Index and count update; wrap relies on a power of two depth
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr             = st_reg.wr + 1'b1;
    end
    if (pop)
    begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Register the state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- rtl/qaso_pkg.sv ----
package qaso_pkg;

  // ********************************************************************
  // Converter word and lane geometry
  // ********************************************************************
  localparam int          QASO_WORD_BITS   = 12;            // Bits in one conversion word
  localparam int          QASO_LANES       = 4;             // Serial data lanes, one per channel
  localparam int          QASO_BITS_PER_HALF = 6;           // Bits sent while frame clock is high
  localparam int          QASO_PIPE_HALVES = 13;            // Latency in half sample periods (6.5 cycles)
  localparam int          QASO_OVR_RECOVER = 4;             // Sample cycles of invalid codes after overload
  localparam logic [11:0] QASO_CODE_MAX    = 12'hfff;       // Positive full scale code
  localparam logic [11:0] QASO_CODE_MIN    = 12'h000;       // Negative full scale code
  localparam int          QASO_FIFO_DEPTH  = 8;             // Frames held between core and serializer

  // ********************************************************************
  // Clock relations
  // ********************************************************************
  localparam real         QASO_CLK_NS      = 10.0;          // Core clock period
  localparam int          QASO_SER_MULT    = 12;            // Serializer rate over sample rate
  localparam int          QASO_BITCLK_MULT = 6;             // Bit clock rate over sample rate
  localparam logic [3:0]  QASO_HALF_LAST   = 4'hb;          // Last serializer slot in a frame
  localparam logic [3:0]  QASO_BITCLK_PER  = 4'h1;          // Bit clock toggles every slot

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] code;        // One word per channel
  } qaso_frame_t;

  typedef struct packed {
    logic [QASO_LANES-1:0] lane_pos;                        // Serial data, true leg
    logic [QASO_LANES-1:0] lane_neg;                        // Serial data, complement leg
    logic                  bit_clk_pos;                     // 6x clock, true leg
    logic                  bit_clk_neg;                     // 6x clock, complement leg
    logic                  frame_clk_pos;                   // 1x clock, true leg
    logic                  frame_clk_neg;                   // 1x clock, complement leg
  } qaso_link_t;

endpackage

// ---- rtl/qaso_top.sv ----
// Summary of operation
// (RULE1) Each channel word serialized on own lane
// (RULE2) One sampling clock drives all channels
// (RULE3) Serializer runs at twelve times sample rate
// (RULE4) Send bit clock 6x, frame clock 1x
// (RULE5) Clocks made by same serializer counter
// (RULE6) Words shifted least significant bit first
// (RULE7) Sample reaches output after 6.5 cycles
// (RULE8) Straight binary, zero to 4095
// (RULE9) Stage outputs corrected, no missing codes
// (RULE10) Valid codes within four cycles after overload
// (RULE11) Receiver finds word start from frame clock
// (RULE12) Receiver captures data on bit clock
// (RULE13) Receiver samples both bit clock edges
`timescale 1ns/100ps

module qaso_top
  import qaso_pkg::*;
(
  // Core clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  // Sampling clock from outside, sampled by ref_clk
  input  wire logic                                  sampling_clock_in,
  // Raw pipeline stage outputs per channel: coarse and fine parts
  input  wire logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] stage_coarse,
  input  wire logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] stage_fine,
  // Overload flags from the analog front end
  input  wire logic [QASO_LANES-1:0]                 overload_in,
  // Serial link
  output qaso_link_t                                 link,
  // Status
  output logic                                       fifo_full_out,
  output logic                                       pll_locked_out
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [1:0]                                   samp_sync;  // Two-flop synchroniser
    logic [1:0][QASO_LANES-1:0][QASO_WORD_BITS-1:0] coarse_sync; // Two-flop capture of coarse parts
    logic [1:0][QASO_LANES-1:0][QASO_WORD_BITS-1:0] fine_sync;   // Two-flop capture of fine parts
    logic [1:0][QASO_LANES-1:0]                   ovr_sync;   // Two-flop capture of overload flags
    logic                                         samp_prev;  // Previous synchronised level
    logic [7:0]                                   period_cnt; // Core cycles in current sample period
    logic [7:0]                                   period_len; // Measured sample period
    logic                                         locked;     // Last measured period at least 13 cycles
    logic [7:0]                                   slot_cnt;   // Core cycles into current slot
    logic [3:0]                                   slot;       // Serializer slot in frame
    logic                                         running;    // Serializer started
    logic [QASO_PIPE_HALVES-1:0][QASO_LANES-1:0][QASO_WORD_BITS-1:0] pipe; // Latency line
    logic [QASO_LANES-1:0][2:0]                   ovr_cnt;    // Overload recovery count
    logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0]    shift;      // Serializer shift words
    qaso_link_t                                   link;       // Link outputs
    logic                                         full;       // Fifo full seen
  } qaso_st_t;

  qaso_st_t                                  st_reg;          // Registered state
  qaso_st_t                                  st_next;         // Next state
  logic                                      samp_rise;       // Sampling clock rising edge
  logic                                      samp_fall;       // Sampling clock falling edge
  logic                                      slot_tick;       // One 12x period elapsed
  logic [7:0]                                slot_len;        // Core cycles per 12x slot
  qaso_frame_t                               corrected;       // Error corrected codes
  logic                                      fifo_in_ready;   // Fifo accepts a frame
  logic                                      fifo_out_valid;  // Fifo holds a frame
  logic                                      fifo_pop;        // Serializer takes a frame
  qaso_frame_t                               fifo_word;       // Frame at fifo head
  logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] pipe_out;        // Code leaving latency line

  // ********************************************************************
  // Edge detection on the sampling clock
  // ********************************************************************
  // Only the second synchroniser flop feeds edge logic
  assign samp_rise = st_reg.samp_sync[1] && !st_reg.samp_prev;   // see (RULE2)
  assign samp_fall = !st_reg.samp_sync[1] && st_reg.samp_prev;

  // Twelve slots per measured period stand in for the internal PLL
  assign slot_len  = 8'(st_reg.period_len / 8'(QASO_SER_MULT));  // see (RULE3)
  assign slot_tick = st_reg.running && (st_reg.slot_cnt + 8'h01 >= slot_len);

  // ********************************************************************
  // Digital error correction
  // ********************************************************************
  // Coarse plus fine with saturation; every code reachable, clipped to range
  // Parts come from the second capture flop; bits may settle a cycle apart, but a word is
  // only taken at a synchronised sampling edge, several core cycles after the front end moved
  always_comb
  begin
    logic [QASO_WORD_BITS:0] sum;
    sum = '0;
    for (int i = 0; i < QASO_LANES; i++)
    begin
      sum = {1'b0, st_reg.coarse_sync[1][i]} + {1'b0, st_reg.fine_sync[1][i]}; // see (RULE9)
      // Straight binary: overflow clips to full scale  see (RULE8)
      corrected.code[i] = sum[QASO_WORD_BITS] ? QASO_CODE_MAX : sum[QASO_WORD_BITS-1:0];
    end
  end

  assign pipe_out = st_reg.pipe[QASO_PIPE_HALVES-1];
  assign fifo_pop = slot_tick && (st_reg.slot == QASO_HALF_LAST) && fifo_out_valid;

  // ********************************************************************
  // Frame buffer between pipeline and serializer
  // ********************************************************************
  qaso_fifo #(
    .WIDTH ($bits(qaso_frame_t)),
    .DEPTH (QASO_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (st_reg.locked && samp_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (pipe_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.samp_sync = {st_reg.samp_sync[0], sampling_clock_in};
    st_next.samp_prev = st_reg.samp_sync[1];
    // Front end words and flags pass two flops before any logic reads them
    st_next.coarse_sync = {st_reg.coarse_sync[0], stage_coarse};
    st_next.fine_sync   = {st_reg.fine_sync[0], stage_fine};
    st_next.ovr_sync    = {st_reg.ovr_sync[0], overload_in};
    // Period measurement from rising edges
    if (samp_rise)
    begin
      st_next.period_len = st_reg.period_cnt + 8'h01;
      st_next.period_cnt = '0;
      st_next.locked     = st_reg.period_cnt >= 8'(QASO_SER_MULT);
      st_next.running    = st_next.locked;
      st_next.slot       = '0;                                     // Frame aligned to sample edge
      st_next.slot_cnt   = '0;
    end
    else
    begin
      st_next.period_cnt = st_reg.period_cnt + 8'h01;
      if (slot_tick)
      begin
        st_next.slot_cnt = '0;
        st_next.slot     = (st_reg.slot == QASO_HALF_LAST) ? 4'h0 : st_reg.slot + 4'h1;
      end
      else if (st_reg.running)
      begin
        st_next.slot_cnt = st_reg.slot_cnt + 8'h01;
      end
    end
    // Latency line advances on both sampling edges: 13 halves  see (RULE7)
    if (samp_rise || samp_fall)
    begin
      for (int h = QASO_PIPE_HALVES-1; h > 0; h--)
      begin
        st_next.pipe[h] = st_reg.pipe[h-1];
      end
      for (int i = 0; i < QASO_LANES; i++)
      begin
        // Force the zero code while recovering from overload  see (RULE10)
        st_next.pipe[0][i] = (st_reg.ovr_cnt[i] != 3'h0) ? QASO_CODE_MIN : corrected.code[i];
      end
    end
    // Overload recovery counters count sample periods
    for (int i = 0; i < QASO_LANES; i++)
    begin
      if (st_reg.ovr_sync[1][i])
      begin
        st_next.ovr_cnt[i] = 3'(QASO_OVR_RECOVER);                  // see (RULE10)
      end
      else if (samp_rise && st_reg.ovr_cnt[i] != 3'h0)
      begin
        st_next.ovr_cnt[i] = st_reg.ovr_cnt[i] - 3'h1;
      end
    end
    // Serializer: load at frame start, then shift one bit per slot
    if (fifo_pop)
    begin
      st_next.shift = fifo_word.code;
    end
    else if (slot_tick)
    begin
      for (int i = 0; i < QASO_LANES; i++)
      begin
        st_next.shift[i] = {1'b0, st_reg.shift[i][QASO_WORD_BITS-1:1]}; // see (RULE6)
      end
    end
    // Outputs from the same slot counter as data  see (RULE5)
    for (int i = 0; i < QASO_LANES; i++)
    begin
      st_next.link.lane_pos[i] = st_reg.shift[i][0];               // see (RULE1)
      st_next.link.lane_neg[i] = !st_reg.shift[i][0];
    end
    st_next.link.frame_clk_pos = st_reg.running && (st_reg.slot < 4'(QASO_BITS_PER_HALF)); // see (RULE4)
    st_next.link.frame_clk_neg = !st_next.link.frame_clk_pos;
    st_next.link.bit_clk_pos   = st_reg.running && !st_reg.slot[0];   // see (RULE4)
    st_next.link.bit_clk_neg   = !st_next.link.bit_clk_pos;
    st_next.full = !fifo_in_ready;
  end

  // Register the whole state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link           = st_reg.link;
  assign fifo_full_out  = st_reg.full;
  assign pll_locked_out = st_reg.locked;

endmodule

// ---- sim/qaso_monitor.sv ----
`timescale 1ns/100ps

// ********************************************************************
// Link timing checker
// ********************************************************************
module qaso_monitor
  import qaso_pkg::*;
(
  // Clock and reset
  input  wire logic                                      ref_clk,
  input  wire logic                                      rst,
  // Converter side
  input  wire logic                                      sampling_clock_in,
  input  wire logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] stage_coarse,
  input  wire logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] stage_fine,
  input  wire logic [QASO_LANES-1:0]                     overload_in,
  // Link and status
  input  wire qaso_link_t                                link,
  input  wire logic                                      fifo_full_out,
  input  wire logic                                      pll_locked_out
);
  logic       bclk_q;   // Bit clock one cycle back
  logic       fr_q;     // Frame clock one cycle back
  logic       seen;     // A frame start has been seen
  logic [4:0] tog_cnt;  // Bit clock toggles since frame start
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Toggle counter; saturates so a stuck frame clock never wraps to a legal figure
  always_ff @(posedge ref_clk)
  begin
    bclk_q <= rst ? 1'b0 : link.bit_clk_pos;
    fr_q <= rst ? 1'b0 : link.frame_clk_pos;
    seen <= rst ? 1'b0 : (seen || (link.frame_clk_pos && !fr_q));
    if (rst || (link.frame_clk_pos && !fr_q))
      tog_cnt <= 5'h00;
    else if (link.bit_clk_pos != bclk_q && tog_cnt != 5'h1f)
      tog_cnt <= tog_cnt + 5'h01;
  end
  sequence s_frame_rise;
    link.frame_clk_pos && !fr_q;
  endsequence
  sequence s_frame_fall;
    fr_q && !link.frame_clk_pos;
  endsequence
  sequence s_bit_toggle;
    $changed(link.bit_clk_pos);
  endsequence
  property p_leg_bit;
    !$past(rst) && !$past(rst, 2) |-> link.bit_clk_neg == !link.bit_clk_pos;
  endproperty
  property p_leg_frame;
    !$past(rst) && !$past(rst, 2) |-> link.frame_clk_neg == !link.frame_clk_pos;
  endproperty
  property p_leg_lane;
    !$past(rst) && !$past(rst, 2) |-> link.lane_neg == ~link.lane_pos;
  endproperty
  property p_quiet;
    !pll_locked_out && !$past(pll_locked_out) |-> !link.frame_clk_pos && !link.bit_clk_pos;
  endproperty
  property p_frame_start;
    s_frame_rise |-> $rose(link.bit_clk_pos);
  endproperty
  property p_frame_high;
    s_frame_fall |-> tog_cnt == 5'h05 ##0 s_bit_toggle;
  endproperty
  property p_frame_period;
    s_frame_rise ##0 seen |-> tog_cnt == 5'h0b;
  endproperty
  property p_lane_lag;
    $changed(link.lane_pos) |-> $changed(link.bit_clk_pos);
  endproperty
  property p_bit_runs;
    pll_locked_out |-> ##[1:100] s_bit_toggle;
  endproperty
  a_leg_bit: assert property (p_leg_bit) else $error("bit clock legs not complementary");
  a_leg_frame: assert property (p_leg_frame) else $error("frame clock legs not complementary");
  a_leg_lane: assert property (p_leg_lane) else $error("lane legs not complementary");
  a_quiet: assert property (p_quiet) else $error("link clocks run without lock");
  a_frame_start: assert property (p_frame_start) else $error("frame start off bit clock rise");
  a_frame_high: assert property (p_frame_high) else $error("frame high not six bit slots");
  a_frame_period: assert property (p_frame_period) else $error("frame not twelve slots");
  a_lane_lag: assert property (p_lane_lag) else $error("lane moved off a bit clock edge");
  a_bit_runs: assert property (p_bit_runs) else $error("bit clock stalled while locked");
endmodule

bind qaso_top qaso_monitor u_mon (.ref_clk, .rst, .sampling_clock_in, .stage_coarse, .stage_fine,
                                  .overload_in, .link, .fifo_full_out, .pll_locked_out);

// ---- sim/qaso_rx_model.sv ----
`timescale 1ns/100ps

// ********************************************************************
// Receiver on the far side of the link
// ********************************************************************
module qaso_rx_model
  import qaso_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Link from the converter
  input  wire qaso_link_t link,
  // Recovered words
  output qaso_frame_t     words,
  output logic            word_stb
);
  logic                                      bclk_q;   // Bit clock one cycle back
  logic                                      fr_q;     // Frame clock one cycle back
  logic                                      edge_d;   // Bit clock edge, aligned to lane data
  logic                                      start_d;  // Frame start, aligned to lane data
  logic [3:0]                                bit_cnt;  // Bits taken, 0 while unaligned
  logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] shift;    // LSB-first shifters
  // Lanes move with the clocks; each edge is used one cycle late, so a bit is taken when settled
  always @(posedge ref_clk)
  begin
    bclk_q <= link.bit_clk_pos;
    fr_q <= link.frame_clk_pos;
    edge_d <= (link.bit_clk_pos != bclk_q) && !rst;
    start_d <= link.frame_clk_pos && !fr_q && !rst;
    word_stb <= 1'b0;
    if (rst)
      bit_cnt <= 4'h0;
    else if (edge_d && (start_d || (bit_cnt != 4'h0 && bit_cnt != 4'hc)))
    begin
      for (int l = 0; l < QASO_LANES; l++)
        shift[l] <= {link.lane_pos[l], shift[l][11:1]};
      bit_cnt <= start_d ? 4'h1 : bit_cnt + 4'h1;
      // Twelfth bit closes the word; a short frame is simply dropped
      if (!start_d && bit_cnt == 4'hb)
      begin
        for (int l = 0; l < QASO_LANES; l++)
          words.code[l] <= {link.lane_pos[l], shift[l][11:1]};
        word_stb <= 1'b1;
      end
    end
  end
endmodule

// ---- sim/qaso_top_tb.sv ----
`timescale 1ns/100ps

// ********************************************************************
// Bench top
// ********************************************************************
module qaso_top_tb;
  import qaso_pkg::*;
  logic                                      ref_clk = 1'b0;            // Core clock
  logic                                      rst = 1'b1;                // Sync reset
  logic                                      sampling_clock_in = 1'b0;  // Sample clock
  logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] stage_coarse = '0;         // Coarse parts
  logic [QASO_LANES-1:0][QASO_WORD_BITS-1:0] stage_fine = '0;           // Fine parts
  logic [QASO_LANES-1:0]                     overload_in = '0;          // Overload flags
  qaso_link_t                                link;                      // Serial link
  logic                                      fifo_full_out;             // Fifo status
  logic                                      pll_locked_out;            // Lock status
  qaso_frame_t                               rx_words;                  // Receiver words
  logic                                      rx_stb;                    // Receiver strobe
  int                                        samp_half = 40;            // Sample half period, ns
  int                                        err_count = 0;             // Mismatches
  int                                        num_checks = 0;            // Comparisons
  logic [11:0]                               pair_c [4] = '{12'h000, 12'h800, 12'hfff, 12'h123};
  logic [11:0]                               pair_f [4] = '{12'h000, 12'h7ff, 12'h001, 12'h456};
  logic [11:0]                               pair_e [4] = '{12'h000, 12'hfff, 12'hfff, 12'h579};
  always #5 ref_clk = ~ref_clk;
  // Sample clock offset by 3 ns so its edges never line up with the core clock
  initial
  begin
    #3;
    forever #(samp_half) sampling_clock_in = ~sampling_clock_in;
  end
  qaso_top u_dut (.ref_clk, .rst, .sampling_clock_in, .stage_coarse, .stage_fine, .overload_in, .link,
                  .fifo_full_out, .pll_locked_out);
  qaso_rx_model u_rx (.ref_clk, .rst, .link, .words(rx_words), .word_stb(rx_stb));
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for receiver words; running out ends the run
  task automatic wait_words(input int n);
    int t;
    t = 0;
    while (n > 0)
    begin
      @(negedge ref_clk);
      t++;
      if (rx_stb === 1'b1)
        n--;
      if (t > 4000)
      begin
        check("word wait", 12'h001, 12'h000);
        conclude();
      end
    end
  endtask
  // An 80 ns sample clock is below the lock floor and must give no frames
  task automatic t_no_lock();
    int strobes;
    strobes = 0;
    repeat (400)
    begin
      @(negedge ref_clk);
      if (rx_stb === 1'b1)
        strobes++;
    end
    check("pll_locked_out", 12'h000, {11'h0, pll_locked_out});
    check("words unlocked", 12'h000, strobes[11:0]);
  endtask
  // Every code pair on every lane, with both full-scale ends and the clipped sum
  task automatic t_codes();
    samp_half = 120;
    for (int r = 0; r < 4; r++)
    begin
      @(negedge ref_clk);
      for (int l = 0; l < QASO_LANES; l++)
      begin
        stage_coarse[l] = pair_c[(r + l) % 4];
        stage_fine[l] = pair_f[(r + l) % 4];
      end
      wait_words(12);
      for (int l = 0; l < QASO_LANES; l++)
        check("lane code", pair_e[(r + l) % 4], rx_words.code[l]);
    end
    check("pll_locked_out", 12'h001, {11'h0, pll_locked_out});
    check("fifo_full_out", 12'h000, {11'h0, fifo_full_out});
  endtask
  // New code must not show before 6.5 sample periods, nor linger past ten
  task automatic t_latency();
    int t;
    t = 0;
    @(posedge sampling_clock_in);
    @(negedge ref_clk);
    stage_coarse[0] = 12'h0a5;
    stage_fine[0] = 12'h000;
    while (!(rx_stb === 1'b1 && rx_words.code[0] === 12'h0a5) && t < 1000)
    begin
      @(negedge ref_clk);
      t++;
    end
    check("latency", 12'h001, {11'h0, t >= 13 * samp_half / 10 && t <= 20 * samp_half / 10});
  endtask
  // Overload on lane 2 zeroes it only; code returns once recovery is over
  task automatic t_overload();
    @(negedge ref_clk);
    overload_in[2] = 1'b1;
    wait_words(12);
    check("overloaded lane", 12'h000, rx_words.code[2]);
    check("neighbour lane", 12'hfff, rx_words.code[3]);
    overload_in[2] = 1'b0;
    wait_words(QASO_OVR_RECOVER + 10);
    check("recovered lane", 12'hfff, rx_words.code[2]);
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_no_lock();
    t_codes();
    t_latency();
    t_overload();
    conclude();
  end
endmodule
